// file: hdl/rhsc_top.sv
// reset hold and strap capture with ahb-lite registers
// What this block does
// RL1 - downstream strap seeds each port slot bit
// RL2 - upstream strap seeds writable upstream slot bit
// RL3 - slow strap picks 100k else 400k
// RL4 - no software override of bus speed
// RL5 - reset pin resets everything, starts port reset
// RL6 - hold strap keeps reset, smbus stays alive
// RL7 - clearing hold bit releases the device
// RL8 - mode 0 normal, 1 eeprom load first
// RL9 - board keeps mode straps steady after reset
// RL10 - eeprom addressed with address strap bits
// RL11 - straps sampled at reset release, then held
// RL12 - board never drives reserved mode values
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module rhsc_top #(
    parameter int N_DN = 2   // number of downstream ports
) (
    // clock and fundamental reset
    input  wire logic            clk,
    input  wire logic            nrst,
    // strap pins
    input  wire logic            common_clock_downstream_strap,
    input  wire logic            common_clock_upstream_strap,
    input  wire logic            eeprom_bus_slow_strap,
    input  wire logic            reset_hold_strap,
    input  wire logic [2:0]      switch_operating_mode_strap,
    input  wire logic [3:0]      eeprom_address_straps,
    // eeprom load handshake
    input  wire logic            eeprom_load_done,
    // ahb-lite slave
    input  wire logic            hsel,
    input  wire logic [7:0]      haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    // device control outputs
    output logic                 port_reset_n,
    output logic                 core_reset_n,
    output logic                 smbus_enable,
    output logic                 eeprom_load_start,
    output logic [3:0]           eeprom_address,
    output logic                 eeprom_bus_tick,
    output logic                 slot_clock_upstream,
    output logic [N_DN-1:0]      slot_clock_downstream
);
    localparam int NS = 11;   // strap bundle width
    localparam logic [1:0] SYNC_DEPTH = 2'h2;   // edges before synchronised straps are valid

    // whole state of the block
    typedef struct packed {
        rhsc_pkg::rhsc_state_t st;       // sequencer state
        logic [7:0]            pcnt;     // reset procedure counter
        logic                  cap;      // straps captured
        logic [1:0]            sdly;     // synchroniser settle count
        rhsc_pkg::rhsc_strap_t strap;    // held strap values
        logic                  hold;     // reset-hold control bit
        logic                  ck_up;    // upstream slot bit
        logic [N_DN-1:0]       ck_dn;    // downstream slot bits
        logic                  wr_pend;  // pending write data phase
        logic [7:0]            wr_addr;  // pending write address
        logic [31:0]           rdata;    // read data
        logic [15:0]           div;      // eeprom bus divider
        logic                  tick;     // eeprom bus tick
        logic                  lstart;   // eeprom load start pulse
        logic                  prst_n;   // port reset output
        logic                  crst_n;   // core reset output
    } rhsc_regs_t;

    rhsc_regs_t r;        // registered state
    rhsc_regs_t next_r;   // next state

    logic [NS-1:0] pin_raw;   // straps as they arrive
    logic [NS-1:0] pin_s;     // synchronised straps

    assign pin_raw = {common_clock_downstream_strap, common_clock_upstream_strap,
                      eeprom_bus_slow_strap, reset_hold_strap,
                      switch_operating_mode_strap, eeprom_address_straps};

    // straps come from pins, so synchronise first
    rhsc_sync #(.W(NS)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (pin_raw),
        .dout (pin_s)
    );

    // true when mode code asks for eeprom load
    function automatic logic wants_eeprom(input logic [2:0] m);
        return m == rhsc_pkg::MODE_EEPROM;
    endfunction

    // read mux for a register offset
    function automatic logic [31:0] read_reg(input rhsc_regs_t s, input logic [7:0] a);
        logic [31:0] v;
        v = '0;
        unique case (a)
            rhsc_pkg::OFF_CTRL:   v[rhsc_pkg::CTRL_HOLD_BIT] = s.hold;
            rhsc_pkg::OFF_STRAP: begin
                v[rhsc_pkg::STRAP_MODE_LSB +: 3] = s.strap.mode;
                v[rhsc_pkg::STRAP_SLOW_BIT]      = s.strap.slow;
                v[rhsc_pkg::STRAP_HOLD_BIT]      = s.strap.hold;
                v[rhsc_pkg::STRAP_CKUP_BIT]      = s.strap.ck_up;
                v[rhsc_pkg::STRAP_CKDN_BIT]      = s.strap.ck_dn;
                v[rhsc_pkg::STRAP_ADDR_LSB +: 4] = s.strap.addr;
            end
            rhsc_pkg::OFF_SLOTCK: begin
                v[rhsc_pkg::SLOT_UP_BIT]           = s.ck_up;
                v[rhsc_pkg::SLOT_DN_LSB +: N_DN]   = s.ck_dn;
            end
            rhsc_pkg::OFF_STATUS: v[3:0] = s.st;
            default:              v = '0;   // unmapped reads zero
        endcase
        return v;
    endfunction

    logic ahb_go;   // valid address phase this cycle
    assign ahb_go = hsel && hready && htrans == rhsc_pkg::HTRANS_NONSEQ
                    && hsize == rhsc_pkg::HSIZE_WORD;

    // next-state logic
    always_comb begin
        next_r        = r;
        next_r.lstart = 1'b0;
        next_r.tick   = 1'b0;
        // RL11 let the synchroniser fill, then capture once
        // capturing earlier would latch the synchroniser reset zeros
        if (!r.cap && r.sdly != SYNC_DEPTH) begin
            next_r.sdly  = r.sdly + 2'h1;
        end else if (!r.cap) begin
            next_r.cap   = 1'b1;
            next_r.strap = pin_s;
            // RL1 seed downstream bits
            next_r.ck_dn = {N_DN{pin_s[NS-1]}};
            // RL2 seed upstream bit
            next_r.ck_up = pin_s[NS-2];
            // RL6 hold bit from strap
            next_r.hold  = pin_s[NS-4];
        end
        // RL3 eeprom bus rate divider
        // RL4 rate follows strap only
        if (r.div == 16'h0000) begin
            next_r.div  = (r.strap.slow ? rhsc_pkg::SLOW_DIV : rhsc_pkg::FAST_DIV) - 16'h0001;
            next_r.tick = r.cap;
        end else begin
            next_r.div  = r.div - 16'h0001;
        end
        // ahb write data phase
        if (r.wr_pend) begin
            next_r.wr_pend = 1'b0;
            unique case (r.wr_addr)
                // RL7 clearing hold releases
                rhsc_pkg::OFF_CTRL:   next_r.hold = hwdata[rhsc_pkg::CTRL_HOLD_BIT];
                rhsc_pkg::OFF_SLOTCK: begin
                    next_r.ck_up = hwdata[rhsc_pkg::SLOT_UP_BIT];
                    next_r.ck_dn = hwdata[rhsc_pkg::SLOT_DN_LSB +: N_DN];
                end
                default:              next_r.hold = r.hold;   // read-only or unmapped
            endcase
        end
        // ahb address phase
        if (ahb_go) begin
            next_r.wr_pend = hwrite;
            next_r.wr_addr = haddr;
            next_r.rdata   = hwrite ? 32'h0000_0000 : read_reg(r, haddr);
        end
        // sequencer
        unique case (r.st)
            rhsc_pkg::ST_PROC: begin
                // RL5 run the reset procedure
                if (r.cap && r.pcnt == rhsc_pkg::RESET_PROC_CYCLES) begin
                    next_r.st = rhsc_pkg::ST_HOLD;
                end else if (r.cap) begin
                    next_r.pcnt = r.pcnt + 8'h01;
                end
            end
            rhsc_pkg::ST_HOLD: begin
                // RL6 stay while hold set
                if (!r.hold) begin
                    // RL8 pick mode
                    if (wants_eeprom(r.strap.mode)) begin
                        next_r.st     = rhsc_pkg::ST_LOAD;
                        next_r.lstart = 1'b1;
                    end else begin
                        next_r.st     = rhsc_pkg::ST_RUN;
                    end
                end
            end
            rhsc_pkg::ST_LOAD: begin
                if (eeprom_load_done) begin
                    next_r.st = rhsc_pkg::ST_RUN;
                end
            end
            rhsc_pkg::ST_RUN: next_r.st = rhsc_pkg::ST_RUN;
            default:          next_r.st = rhsc_pkg::ST_PROC;
        endcase
        // port reset released after procedure, core after hold
        next_r.prst_n = next_r.st != rhsc_pkg::ST_PROC;
        next_r.crst_n = next_r.st == rhsc_pkg::ST_LOAD || next_r.st == rhsc_pkg::ST_RUN;
    end

    // RL5 reset clears all state, sequencer starts in ST_PROC
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r        <= '0;
            r.st     <= rhsc_pkg::ST_PROC;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from state, bus handshake tied to constants
    assign hrdata                = r.rdata;
    assign hreadyout             = 1'b1;   // zero wait states
    assign hresp                 = 1'b0;   // always okay
    assign port_reset_n          = r.prst_n;
    assign core_reset_n          = r.crst_n;
    // RL6 smbus alive once captured
    assign smbus_enable          = r.cap;
    assign eeprom_load_start     = r.lstart;
    // RL10 eeprom address from straps
    assign eeprom_address        = r.strap.addr;
    assign eeprom_bus_tick       = r.tick;
    assign slot_clock_upstream   = r.ck_up;
    assign slot_clock_downstream = r.ck_dn;
endmodule // rhsc_top

// file: inc/rhsc_pkg.sv
// package of constants and carrier types for the reset/strap block
package rhsc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;   // switch control register
    localparam logic [7:0] OFF_STRAP  = 8'h04;   // captured straps (read only)
    localparam logic [7:0] OFF_SLOTCK = 8'h08;   // slot clock bits of all ports
    localparam logic [7:0] OFF_STATUS = 8'h0C;   // sequencer state (read only)
    // control register fields
    localparam int CTRL_HOLD_BIT = 0;            // reset-hold bit, write zero to release
    // slot clock register fields
    localparam int SLOT_UP_BIT   = 0;            // upstream port bit
    localparam int SLOT_DN_LSB   = 1;            // first downstream port bit
    // strap register fields
    localparam int STRAP_MODE_LSB = 0;           // mode, 3 bits
    localparam int STRAP_SLOW_BIT = 3;
    localparam int STRAP_HOLD_BIT = 4;
    localparam int STRAP_CKUP_BIT = 5;
    localparam int STRAP_CKDN_BIT = 6;
    localparam int STRAP_ADDR_LSB = 8;           // eeprom address, 4 bits
    // switch mode codes
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_EEPROM = 3'h1;
    // eeprom bus rates and system clock
    localparam int CLK_HZ       = 40_000_000;
    localparam int SLOW_BUS_HZ  = 100_000;
    localparam int FAST_BUS_HZ  = 400_000;
    localparam logic [15:0] SLOW_DIV = 16'(CLK_HZ / (2 * SLOW_BUS_HZ));
    localparam logic [15:0] FAST_DIV = 16'(CLK_HZ / (2 * FAST_BUS_HZ));
    // length of the internal reset procedure in cycles
    localparam logic [7:0] RESET_PROC_CYCLES = 8'h10;
    // ahb transfer codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    // sequencer states
    typedef enum logic [3:0] {
        ST_PROC = 4'b0001,   // running reset procedure
        ST_HOLD = 4'b0010,   // held in reset, smbus alive
        ST_LOAD = 4'b0100,   // eeprom initialization
        ST_RUN  = 4'b1000    // normal operation
    } rhsc_state_t;
    // captured strap set
    typedef struct packed {
        logic       ck_dn;
        logic       ck_up;
        logic       slow;
        logic       hold;
        logic [2:0] mode;
        logic [3:0] addr;
    } rhsc_strap_t;
endpackage

// file: hdl/rhsc_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module rhsc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;   // first stage, read only by second
    // two stages
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // rhsc_sync

// file: tb/rhsc_checker.sv
// concurrent checks for the reset hold and strap block
`timescale 1ns/1ps
module rhsc_checker #(parameter int N_DN = 2) (
    // clock, reset and straps
    input wire logic clk, nrst, common_clock_downstream_strap, common_clock_upstream_strap,
    input wire logic eeprom_bus_slow_strap,
    input wire logic [2:0] switch_operating_mode_strap,
    input wire logic [3:0] eeprom_address_straps,
    // register bus
    input wire logic hsel, hwrite, hready,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [31:0] hwdata,
    // device outputs
    input wire logic port_reset_n, core_reset_n, smbus_enable, eeprom_load_start,
    input wire logic eeprom_bus_tick, slot_clock_upstream,
    input wire logic [3:0] eeprom_address,
    input wire logic [N_DN-1:0] slot_clock_downstream
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    int   gap;  // cycles since the last tick
    logic seen; // one tick already seen
    // tick spacing counter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap  <= 0;
            seen <= 1'b0;
        end else begin
            gap  <= eeprom_bus_tick ? 1 : gap + 1;
            seen <= seen | eeprom_bus_tick;
        end
    end
    // device held with normal mode
    sequence held_s;
        port_reset_n && !core_reset_n && switch_operating_mode_strap == rhsc_pkg::MODE_NORMAL;
    endsequence
    // zero written to the hold bit
    sequence clear_s;
        hsel && hready && hwrite && htrans == rhsc_pkg::HTRANS_NONSEQ
            && haddr == rhsc_pkg::OFF_CTRL ##1 !hwdata[rhsc_pkg::CTRL_HOLD_BIT];
    endsequence
    hold_release_a: assert property (held_s ##0 clear_s |-> ##[1:4] core_reset_n)
        else $error("hold clear did not release core");
    bus_rate_a: assert property (eeprom_bus_tick && seen |-> gap == int'(eeprom_bus_slow_strap ?
        rhsc_pkg::SLOW_DIV : rhsc_pkg::FAST_DIV)) else $error("bus tick spacing wrong");
    load_mode_a: assert property (eeprom_load_start |-> switch_operating_mode_strap ==
        rhsc_pkg::MODE_EEPROM) else $error("load started in wrong mode");
    load_addr_a: assert property (eeprom_load_start |-> eeprom_address == eeprom_address_straps)
        else $error("eeprom address wrong");
    core_order_a: assert property (core_reset_n |-> port_reset_n)
        else $error("core out of reset before ports");
    smb_alive_a: assert property (port_reset_n && !core_reset_n |-> smbus_enable)
        else $error("smbus off during hold");
    slot_seed_a: assert property ($rose(port_reset_n) |-> slot_clock_upstream ==
        common_clock_upstream_strap && slot_clock_downstream == {N_DN{common_clock_downstream_strap}})
        else $error("slot bits not seeded");
    strap_keep_a: assert property (port_reset_n |-> $stable(eeprom_address))
        else $error("captured address moved");
endmodule // rhsc_checker
bind rhsc_top rhsc_checker #(.N_DN(N_DN)) u_chk (.clk, .nrst, .common_clock_downstream_strap,
    .common_clock_upstream_strap, .eeprom_bus_slow_strap, .switch_operating_mode_strap,
    .eeprom_address_straps, .hsel, .hwrite, .hready, .haddr, .htrans, .hwdata, .port_reset_n,
    .core_reset_n, .smbus_enable, .eeprom_load_start, .eeprom_bus_tick, .slot_clock_upstream,
    .eeprom_address, .slot_clock_downstream);

// file: tb/rhsc_board.sv
// board model: strap drivers and eeprom loader answer
`timescale 1ns/1ps
module rhsc_board (
    // clock and board reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // wanted straps and answer delay
    input  wire rhsc_pkg::rhsc_strap_t cfg,
    input  wire logic [7:0]            lat,
    // load handshake and strap pins
    input  wire logic                  load_start,
    output logic                       load_done,
    output rhsc_pkg::rhsc_strap_t      pins
);
    logic [7:0] cnt; // cycles left before done
    // straps move only in reset, mode legal
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pins      <= cfg;
            pins.mode <= {2'h0, cfg.mode[0]};
        end
    end
    // answer a load request after lat cycles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt       <= 8'h00;
            load_done <= 1'b0;
        end else begin
            load_done <= (cnt == 8'h01);
            cnt       <= load_start ? lat : (cnt != 8'h00 ? cnt - 8'h01 : cnt);
        end
    end
endmodule // rhsc_board

// file: tb/tb_reset_halt_and_strap_config.sv
// self-checking bench for the reset hold and strap block
`timescale 1ns/1ps
module tb_reset_halt_and_strap_config;
    logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, done;
    logic [7:0] haddr = 8'h00, lat = 8'h01;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hready, hreadyout, hresp, port_reset_n, core_reset_n, smbus_enable, eeprom_load_start;
    logic eeprom_bus_tick, slot_clock_upstream;
    logic [3:0] eeprom_address;
    logic [1:0] slot_clock_downstream;
    rhsc_pkg::rhsc_strap_t cfg = '0, pins;
    int err_total = 0, n_tests = 0, cyc = 0, n_load = 0, n_done = 0;
    assign hready = hreadyout;
    always #12.5 clk = ~clk;
    rhsc_board board (.clk, .nrst, .cfg, .lat, .load_start(eeprom_load_start), .load_done(done),
        .pins);
    rhsc_top dut (.clk, .nrst, .common_clock_downstream_strap(pins.ck_dn),
        .common_clock_upstream_strap(pins.ck_up), .eeprom_bus_slow_strap(pins.slow),
        .reset_hold_strap(pins.hold), .switch_operating_mode_strap(pins.mode),
        .eeprom_address_straps(pins.addr), .eeprom_load_done(done), .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .port_reset_n,
        .core_reset_n, .smbus_enable, .eeprom_load_start, .eeprom_address, .eeprom_bus_tick,
        .slot_clock_upstream, .slot_clock_downstream);
    // hang guard and load pulse count
    always @(posedge clk) begin
        cyc++;
        n_load += (eeprom_load_start === 1'b1);
        n_done += (done === 1'b1);
        if (cyc > 20000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t reg %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t pin %h want %h", $time, got, exp);
        end
    endtask
    // one single word transfer, called just after an edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= rhsc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        hsize <= rhsc_pkg::HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk_pin(8'(hresp), 8'h00);
    endtask
    // one reset run with a strap set
    task automatic run(input int i);
        int n;
        int slot_m;
        @(posedge clk);
        cfg <= '{ck_dn: 1'($urandom), ck_up: 1'($urandom), slow: i[0], hold: i == 0 || i == 3,
                 mode: 3'(i == 1), addr: 4'($urandom)};
        lat <= 8'($urandom_range(20, 1));
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        n_load = 0;
        n_done = 0;
        @(posedge clk);
        chk_pin(8'({port_reset_n, core_reset_n, smbus_enable}), 8'h00);
        while (port_reset_n !== 1'b1) @(posedge clk);
        chk_pin(8'(eeprom_address), 8'(cfg.addr));
        chk_pin(8'({slot_clock_downstream, slot_clock_upstream}), 8'({{2{cfg.ck_dn}}, cfg.ck_up}));
        chk_pin(8'(smbus_enable), 8'h01);
        ahb(1'b1, rhsc_pkg::OFF_STRAP, $urandom);
        ahb(1'b0, rhsc_pkg::OFF_STRAP, 32'h0);
        chk_reg(rd, {20'h0, cfg.addr, 1'b0, cfg.ck_dn, cfg.ck_up, cfg.hold, cfg.slow, cfg.mode});
        slot_m = $urandom_range(7, 0);
        ahb(1'b1, rhsc_pkg::OFF_SLOTCK, slot_m);
        ahb(1'b0, rhsc_pkg::OFF_SLOTCK, 32'h0);
        chk_reg(rd, slot_m);
        ahb(1'b1, 8'h10, $urandom);
        ahb(1'b0, 8'h10, 32'h0);
        chk_reg(rd, 32'h0);
        if (cfg.hold) begin
            repeat (8) @(posedge clk);
            chk_pin(8'(core_reset_n), 8'h00);
            ahb(1'b0, rhsc_pkg::OFF_STATUS, 32'h0);
            chk_reg(rd, 32'h2);
            ahb(1'b1, rhsc_pkg::OFF_CTRL, 32'h0);
        end
        while (core_reset_n !== 1'b1 || n_done < n_load) @(posedge clk);
        ahb(1'b0, rhsc_pkg::OFF_STATUS, 32'h0);
        chk_reg(rd, 32'h8);
        chk_pin(8'(n_load), 8'(cfg.mode == rhsc_pkg::MODE_EEPROM));
        while (eeprom_bus_tick !== 1'b1) @(posedge clk);
        @(posedge clk);
        n = 1;
        while (eeprom_bus_tick !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk_pin(8'(n), 8'(cfg.slow ? rhsc_pkg::SLOW_DIV : rhsc_pkg::FAST_DIV));
    endtask
    // main sequence
    initial begin
        void'($urandom(32'h5B1E1E7D));
        for (int i = 0; i < 4; i++) run(i);
        stop_test();
    end
endmodule // tb_reset_halt_and_strap_config
